// [abmp_host.v]
`timescale 1ns/100ps
`default_nettype none
`include "abmp_map.vh"

module abmp_host #(
	parameter STARTUP_CYC = `ABMP_STARTUP_CYC
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_srst,
	// user request
	input wire i_req,
	input wire i_req_write,
	input wire [`ABMP_ADDR_W-1:0] i_req_addr,
	input wire [`ABMP_DATA_W-1:0] i_req_wdata,
	output reg o_ready,
	output reg o_rvalid,
	output reg [`ABMP_DATA_W-1:0] o_rdata,
	// memory pins
	output reg [`ABMP_ADDR_W-1:0] o_mem_addr,
	output reg o_mem_select_n,
	output reg o_mem_store_n,
	output reg o_mem_permit_n,
	input wire [`ABMP_DATA_W-1:0] i_mem_dq,
	output reg [`ABMP_DATA_W-1:0] o_mem_dq,
	output reg o_mem_dq_oe
);
	// ----------------------------------------------------------------
	// cycle arithmetic
	// ----------------------------------------------------------------
	// least time in whole cycles, rounded up; every count here fits four bits
	function [3:0] ns_to_cyc;
		input integer ns;
		integer cyc;
		begin
			cyc = `ABMP_CYC(ns);
			ns_to_cyc = cyc[3:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	// address is set one cycle before select falls, so select access governs read
	localparam [3:0] RD_CYC = ns_to_cyc(`ABMP_T_SELECT_ACCESS_NS);
	// the longer of address-to-end and pulse width sets the strobe length
	localparam [3:0] WR_CYC = (ns_to_cyc(`ABMP_T_INDEX_TO_STORE_END_NS) >
		ns_to_cyc(`ABMP_T_STORE_PULSE_NS)) ? ns_to_cyc(`ABMP_T_INDEX_TO_STORE_END_NS) :
		ns_to_cyc(`ABMP_T_STORE_PULSE_NS);
	localparam [3:0] FLOAT_CYC = ns_to_cyc(`ABMP_T_DESELECT_TO_FLOAT_NS);
	localparam [3:0] TURN_CYC = ns_to_cyc(`ABMP_T_STORE_TO_FLOAT_NS);
	localparam [3:0] CYC_MIN = ns_to_cyc(`ABMP_T_CYCLE_MIN_NS);
	localparam [3:0] SETUP_CYC = ns_to_cyc(`ABMP_T_BYTE_SETUP_STORE_NS);
	localparam [3:0] HIGH_CYC = ns_to_cyc(`ABMP_T_HIGH_HOLD_NS);
	// the capture flops add their own delay to every read
	localparam [3:0] PIPE_CYC = `ABMP_CAPTURE_CYC;
	// last boot count; startup is counted from the release of reset
	localparam [31:0] BOOT_LAST = STARTUP_CYC - 1;

	// ----------------------------------------------------------------
	// state codes
	// ----------------------------------------------------------------
	localparam [2:0] ST_BOOT = 3'h0;
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_SETUP = 3'h2;
	localparam [2:0] ST_READ = 3'h3;
	localparam [2:0] ST_WTURN = 3'h4;
	localparam [2:0] ST_WRITE = 3'h5;
	localparam [2:0] ST_RECOV = 3'h6;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [2:0] state_q;
	reg [3:0] cnt_q;
	reg [3:0] span_q;
	reg [31:0] boot_q;
	reg write_q;
	reg [`ABMP_DATA_W-1:0] dq_s1_q;
	reg [`ABMP_DATA_W-1:0] dq_s2_q;

	// ----------------------------------------------------------------
	// data capture
	// ----------------------------------------------------------------
	// two-stage capture; adds two cycles, covered by the read margin
	always @(posedge i_clk_sys) begin
		dq_s1_q <= i_mem_dq;
		dq_s2_q <= dq_s1_q;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			// all controls high under reset, so the device stays deselected
			state_q <= ST_BOOT;
			cnt_q <= 4'h0;
			span_q <= 4'h0;
			boot_q <= 32'h0;
			write_q <= 1'b0;
			o_ready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= `ABMP_RST_DATA;
			o_mem_addr <= `ABMP_RST_ADDR;
			o_mem_select_n <= 1'b1;
			o_mem_store_n <= 1'b1;
			o_mem_permit_n <= 1'b1;
			o_mem_dq <= `ABMP_RST_DATA;
			o_mem_dq_oe <= 1'b0;
		end else begin
			o_rvalid <= 1'b0;
			// cycle span counter from select fall, for spacing
			// it saturates, so a long idle never wraps into a short cycle
			if (span_q != 4'hF)
				span_q <= span_q + 4'h1;
			case (state_q)
			ST_BOOT: begin
				// controls held high through the startup time
				// 2 ms at the full clock; a bench may shorten it by the parameter
				if (boot_q == BOOT_LAST) begin
					state_q <= ST_IDLE;
					o_ready <= 1'b1;
				end else begin
					boot_q <= boot_q + 32'h1;
				end
			end
			ST_IDLE: begin
				// taken only here; a request raised while busy waits, it is not queued
				if (i_req) begin
					o_ready <= 1'b0;
					write_q <= i_req_write;
					o_mem_addr <= i_req_addr;
					o_mem_dq <= i_req_wdata;
					state_q <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				// address stable before select falls; a write drops the strobe on the same edge as select
				o_mem_select_n <= 1'b0;
				span_q <= 4'h0;
				cnt_q <= 4'h0;
				if (write_q) begin
					// permit stays high so the device never drives
					o_mem_store_n <= 1'b0;
					state_q <= ST_WTURN;
				end else begin
					o_mem_permit_n <= 1'b0;
					state_q <= ST_READ;
				end
			end
			ST_READ: begin
				cnt_q <= cnt_q + 4'h1;
				// sample after access time plus the capture pipeline
				if (cnt_q == RD_CYC + PIPE_CYC) begin
					o_rdata <= dq_s2_q;
					o_rvalid <= 1'b1;
					o_mem_select_n <= 1'b1;
					o_mem_permit_n <= 1'b1;
					cnt_q <= 4'h0;
					state_q <= ST_RECOV;
				end
			end
			ST_WTURN: begin
				cnt_q <= cnt_q + 4'h1;
				// wait for the device to float before driving
				// the strobe alone turns the device off, permit never drops in a write
				if (cnt_q == TURN_CYC - 4'h1) begin
					o_mem_dq_oe <= 1'b1;
					cnt_q <= 4'h0;
					state_q <= ST_WRITE;
				end
			end
			ST_WRITE: begin
				cnt_q <= cnt_q + 4'h1;
				// store happens in the overlap of select and strobe low
				if (cnt_q >= SETUP_CYC - 4'h1 &&
					span_q >= WR_CYC - 4'h1) begin
					o_mem_store_n <= 1'b1;
					o_mem_select_n <= 1'b1;
					cnt_q <= 4'h0;
					state_q <= ST_RECOV;
				end
			end
			ST_RECOV: begin
				cnt_q <= cnt_q + 4'h1;
				// data held one cycle past strobe rise, then released
				o_mem_dq_oe <= 1'b0;
				// controls stay high; select spacing and device float
				if (cnt_q >= HIGH_CYC - 4'h1 &&
					cnt_q >= FLOAT_CYC - 4'h1 && span_q >= CYC_MIN) begin
					o_ready <= 1'b1;
					state_q <= ST_IDLE;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // abmp_host
`default_nettype wire

// [abmp_host_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module abmp_host_chk #(parameter int STARTUP_CYC = 20) (
	// host pins seen at the top
	input wire logic i_clk_sys, i_srst, o_ready, o_mem_dq_oe,
	input wire logic o_mem_select_n, o_mem_store_n, o_mem_permit_n,
	input wire logic [20:0] o_mem_addr,
	input wire logic [7:0] o_mem_dq
);
	// ----
	// pin order
	// ----
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	int cnt_q;
	always @(posedge i_clk_sys) cnt_q <= i_srst ? 0 : cnt_q + (cnt_q < STARTUP_CYC);
	sequence s_wr_end; $rose(o_mem_store_n); endsequence
	chk_read_store_high: assert property (!o_mem_permit_n |-> o_mem_store_n)
		else $error("store low in read");
	chk_store_in_sel: assert property (!o_mem_store_n |-> !o_mem_select_n)
		else $error("store outside select");
	chk_addr_steady: assert property (!o_mem_select_n && !$past(o_mem_select_n) |-> $stable(o_mem_addr))
		else $error("addr moved in cycle");
	chk_addr_setup: assert property (s_wr_end |-> $stable(o_mem_addr))
		else $error("addr late");
	chk_pulse_wide: assert property ($fell(o_mem_store_n) |=> !o_mem_store_n)
		else $error("store pulse short");
	chk_data_setup: assert property (s_wr_end |-> $past(o_mem_dq_oe) && $stable(o_mem_dq))
		else $error("data late");
	chk_high_hold: assert property ($rose(o_mem_select_n) |=> o_mem_select_n && o_mem_store_n)
		else $error("control high too short");
	chk_startup_idle: assert property (cnt_q < STARTUP_CYC - 1 |-> o_mem_select_n && o_mem_store_n && !o_ready)
		else $error("access in startup");
endmodule // abmp_host_chk
bind abmp_host abmp_host_chk #(.STARTUP_CYC(STARTUP_CYC)) u_chk(.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.o_ready(o_ready), .o_mem_dq_oe(o_mem_dq_oe), .o_mem_select_n(o_mem_select_n),
	.o_mem_store_n(o_mem_store_n), .o_mem_permit_n(o_mem_permit_n), .o_mem_addr(o_mem_addr),
	.o_mem_dq(o_mem_dq));
`default_nettype wire

// [abmp_host_test.sv]
`timescale 1ns/100ps
`default_nettype none
module abmp_host_test;
	logic clk = 0, srst = 1, req = 0, wr = 0;
	logic [20:0] a = 21'h000000;
	logic [7:0] wd = 8'h00;
	wire ready, rvalid, sel_n, st_n, pm_n, oe;
	wire [7:0] rdata, dq_o, dq_m;
	wire [20:0] ma;
	int error_cnt = 0, tests_run = 0;
	always #20 clk = ~clk;
	abmp_host #(.STARTUP_CYC(20)) dut(.i_clk_sys(clk), .i_srst(srst), .i_req(req), .i_req_write(wr),
		.i_req_addr(a), .i_req_wdata(wd), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_mem_addr(ma), .o_mem_select_n(sel_n), .o_mem_store_n(st_n), .o_mem_permit_n(pm_n),
		.i_mem_dq(oe ? dq_o : dq_m), .o_mem_dq(dq_o), .o_mem_dq_oe(oe));
	abmp_mem_model mem(.i_addr(ma), .i_sel_n(sel_n), .i_st_n(st_n), .i_pm_n(pm_n),
		.i_dq(oe ? dq_o : dq_m), .o_dq(dq_m));
	// ----
	// shared tasks
	// ----
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic go(input logic w, input logic [20:0] ad, input logic [7:0] d, input logic [7:0] exp);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 300) begin @(posedge clk); #1 n++; end
		wr = w; a = ad; wd = d; req = 1;
		@(posedge clk); #1 req = 0;
		chk({7'h00, ready}, 8'h00);
		while (!w && rvalid !== 1'b1 && n < 300) begin @(posedge clk); #1 n++; end
		if (n >= 300) begin error_cnt++; finish_test; end
		else if (!w) begin
			chk(rdata, exp);
			@(posedge clk); #1 chk({7'h00, rvalid}, 8'h00);
		end
	endtask
	task automatic sc_startup;
		repeat (18) begin @(posedge clk); #1 chk({5'h00, ready, sel_n, st_n}, 8'h03); end
	endtask
	task automatic sc_edges;
		go(1, 21'h000000, 8'h3C, 8'h00);
		go(1, 21'h1FFFFF, 8'hC3, 8'h00);
		go(0, 21'h000000, 8'h00, 8'h3C);
		go(0, 21'h1FFFFF, 8'h00, 8'hC3);
	endtask
	task automatic sc_rewrite;
		go(1, 21'h000155, 8'h55, 8'h00);
		go(1, 21'h000155, 8'hAA, 8'h00);
		go(0, 21'h000155, 8'h00, 8'hAA);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		#1 srst = 0;
		sc_startup;
		sc_edges;
		sc_rewrite;
		finish_test;
	end
endmodule // abmp_host_test
`default_nettype wire

// [abmp_map.vh]
`ifndef ABMP_MAP_VH
`define ABMP_MAP_VH
// ----------------------------------------------------------------
// clock and widths
// ----------------------------------------------------------------
`define ABMP_CLK_MHZ 25
`define ABMP_ADDR_W 21
`define ABMP_DATA_W 8
// ----------------------------------------------------------------
// pin timing in ns, and derived cycle counts
// ----------------------------------------------------------------
`define ABMP_T_CYCLE_MIN_NS 35
`define ABMP_T_SELECT_ACCESS_NS 35
`define ABMP_T_PERMIT_ACCESS_NS 15
`define ABMP_T_UNPERMIT_TO_FLOAT_NS 10
`define ABMP_T_DESELECT_TO_FLOAT_NS 15
`define ABMP_T_INDEX_TO_STORE_END_NS 20
`define ABMP_T_STORE_PULSE_NS 15
`define ABMP_T_BYTE_SETUP_STORE_NS 10
`define ABMP_T_STORE_TO_FLOAT_NS 12
`define ABMP_T_HIGH_HOLD_NS 2
`define ABMP_T_STARTUP_US 2000
// capture flops between the data pins and the read register
`define ABMP_CAPTURE_CYC 4'h2
// least times round up: ceil(ns * mhz / 1000), never below one cycle
`define ABMP_CYC(ns) ((((ns) * `ABMP_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
	(((ns) * `ABMP_CLK_MHZ + 999) / 1000))
`define ABMP_STARTUP_CYC (`ABMP_T_STARTUP_US * `ABMP_CLK_MHZ)
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ABMP_RST_ADDR 21'h000000
`define ABMP_RST_DATA 8'h00
`endif

// [abmp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module abmp_mem_model (
	input wire logic [20:0] i_addr,
	input wire logic i_sel_n, i_st_n, i_pm_n,
	input wire logic [7:0] i_dq,
	output logic [7:0] o_dq
);
	// ----
	// byte store
	// ----
	logic [7:0] mem [0:2097151];
	logic [7:0] rd_late = 8'h00;
	logic drive_on = 1'b0;
	wire [7:0] rd_byte;
	wire drive = !i_sel_n && !i_pm_n && i_st_n;
	wire store_win = !i_sel_n && !i_st_n;
	// the byte lands as the overlap of select and strobe closes
	always @(negedge store_win) mem[i_addr] <= i_dq;
	assign rd_byte = mem[i_addr];
	// data follows the address 5 ns late, so the old byte holds past 3 ns
	always @(rd_byte) rd_late <= #5 rd_byte;
	// drive 5 ns after enable, float 2 ns after release: floating is always quicker
	always @(drive) begin
		if (drive) drive_on <= #5 1'b1;
		else drive_on <= #2 1'b0;
	end
	// a floating bus shows the inverse of the last byte, never the byte itself
	assign o_dq = drive_on ? rd_late : ~rd_late;
endmodule // abmp_mem_model
`default_nettype wire
